/* hw/out4_cfg_map.vh */
/*
 * Register map, field positions and reset values for the channel 4 output
 * configuration block. Included by the design files; it holds definitions
 * only.
 */
`ifndef OUT4_CFG_MAP_VH
`define OUT4_CFG_MAP_VH

// Register indices; the byte address is four times the index.
`define IDX_CH23_INTEGER_DIVIDER 4'h8
`define IDX_CH4_OUTPUT_CONFIG 4'h9
`define IDX_CH4_DIVIDER_UPPER 4'hA
`define IDX_CH4_DIVIDER_LOWER 4'hB
`define IDX_CH4_STATUS 4'hF

// Writable bit masks; every other bit is reserved and reads as zero.
`define MASK_CH23_INTEGER_DIVIDER 16'h00FF
`define MASK_CH4_OUTPUT_CONFIG 16'h7FDF
`define MASK_CH4_DIVIDER_UPPER 16'h0FFF
`define MASK_CH4_DIVIDER_LOWER 16'hFFFF

// Reset values.
`define RST_CH23_INTEGER_DIVIDER 16'h0000
`define RST_CH4_OUTPUT_CONFIG 16'h0000
`define RST_CH4_DIVIDER_UPPER 16'h0000
`define RST_CH4_DIVIDER_LOWER 16'h0000

// Field positions in the channel 2/3 divider register.
`define PAIR_B_RATIO_HI 7
`define PAIR_B_RATIO_LO 0

// Field positions in the channel 4 configuration register.
`define SRC_SEL_HI 14
`define SRC_SEL_LO 13
`define PRESCALE_HI 12
`define PRESCALE_LO 10
`define FRAC_ON_BIT 9
`define EDGE_RATE_BIT 8
`define NEG_ON_BIT 7
`define POS_ON_BIT 6
`define DRV_TYPE_HI 4
`define DRV_TYPE_LO 3
`define OUT_CTRL_HI 2
`define OUT_CTRL_LO 1
`define SUPPLY_BIT 0

// Field positions in the channel 4 divider register.
`define OUT4_RATIO_HI 11
`define OUT4_RATIO_LO 4
`define FRAC_TOP_HI 3
`define FRAC_TOP_LO 0

// Source selector codes.
`define SRC_PLL_A 2'b00
`define SRC_PRIMARY 2'b01
`define SRC_SECONDARY 2'b10
`define SRC_PLL_B 2'b11

// Prescaler codes and the divider ratio field each one loads.
`define PRESCALE_DIV2 3'b000
`define PRESCALE_DIV3 3'b001
`define PRESCALE_DIV1 3'b111
`define RATIO_DIV1 8'h00
`define RATIO_DIV2 8'h01
`define RATIO_DIV3 8'h02

// Driver type codes.
`define DRV_LVDS_A 2'b00
`define DRV_LVDS_B 2'b01
`define DRV_LVCMOS 2'b10
`define DRV_HCSL 2'b11

// Output control codes.
`define CTRL_OFF 2'b00
`define CTRL_RUN 2'b01
`define CTRL_LOW 2'b10
`define CTRL_HIGH 2'b11

`endif

/* hw/ratio_divider.v */
/*
 * Tick divider: emits one output tick for every (ratio + 1) input ticks,
 * optionally stretched by a 20-bit fraction through a phase accumulator.
 * Assumes input ticks are one-cycle pulses on core_clk.
 */
module ratio_divider (
    // Clock and reset.
    input wire core_clk,
    input wire srst,
    // Tick stream and settings.
    input wire inTick,
    input wire [7:0] ratio,
    input wire [19:0] fraction,
    input wire fracOn,
    // Divided tick.
    output reg outTick
);
    reg [8:0] count_r;
    reg [19:0] phase_r;
    reg extra_r;
    wire [20:0] phaseSum;
    wire [8:0] target;

    assign phaseSum = {1'b0, phase_r} + {1'b0, fraction};
    assign target = {1'b0, ratio} + {8'h00, extra_r};

    always @(posedge core_clk) begin
        if (srst) begin
            count_r <= 9'h000;
            phase_r <= 20'h0_0000;
            extra_r <= 1'b0;
            outTick <= 1'b0;
        end else begin
            outTick <= 1'b0;
            if (inTick) begin
                if (count_r >= target) begin
                    // A carry out of the accumulator lengthens the next
                    // period by one input tick, so the average ratio is
                    // ratio + 1 + fraction / 2^20.
                    outTick <= 1'b1;
                    count_r <= 9'h000;
                    if (fracOn) begin
                        phase_r <= phaseSum[19:0];
                        extra_r <= phaseSum[20];
                    end else begin
                        phase_r <= 20'h0_0000;
                        extra_r <= 1'b0;
                    end
                end else begin
                    count_r <= count_r + 9'h001;
                end
            end
        end
    end
endmodule // ratio_divider

/* hw/out_stage.v */
/*
 * Output driver stage of channel 4: turns the divided phase and the driver
 * settings into registered pin levels and enables.
 * Assumes all inputs are on core_clk.
 */
module out_stage (
    // Clock and reset.
    input wire core_clk,
    input wire srst,
    // Divided clock phase.
    input wire phase,
    // Settings.
    input wire [1:0] control,
    input wire [1:0] driverType,
    input wire posOn,
    input wire negOn,
    // Pins.
    output reg pinPos,
    output reg pinNeg,
    output reg pinPosOe,
    output reg pinNegOe,
    // Driver selects.
    output reg lvdsSel,
    output reg lvcmosSel,
    output reg hcslSel
);
`include "out4_cfg_map.vh"
    reg level;
    reg enabled;
    reg singleEnded;

    always @* begin
        case (control)
            `CTRL_RUN: level = phase;
            `CTRL_HIGH: level = 1'b1;
            default: level = 1'b0;
        endcase
        enabled = (control != `CTRL_OFF);
        singleEnded = (driverType == `DRV_LVCMOS);
    end

    always @(posedge core_clk) begin
        if (srst) begin
            pinPos <= 1'b0;
            pinNeg <= 1'b0;
            pinPosOe <= 1'b0;
            pinNegOe <= 1'b0;
            lvdsSel <= 1'b0;
            lvcmosSel <= 1'b0;
            hcslSel <= 1'b0;
        end else begin
            pinPos <= level;
            pinNeg <= ~level;
            lvdsSel <= (driverType == `DRV_LVDS_A) ||
                (driverType == `DRV_LVDS_B);
            lvcmosSel <= singleEnded;
            hcslSel <= (driverType == `DRV_HCSL);
            if (singleEnded) begin
                pinPosOe <= enabled && posOn;
                // The negative side is held off unless the positive side
                // is on, even if software sets its bit alone.
                pinNegOe <= enabled && posOn && negOn;
            end else begin
                pinPosOe <= enabled;
                pinNegOe <= enabled;
            end
        end
    end
endmodule // out_stage

/* hw/output_channel_four_config.v */
/*
 * Channel 4 output configuration block with the shared channel 2/3 integer
 * divider: an Avalon-MM slave register file steering a source mux, a
 * prescaler, integer and fractional dividers and the output stage.
 * Assumes one clock, core_clk at 40 MHz, synchronous active-high srst, and
 * source ticks that are one-cycle pulses on core_clk.
 */
module output_channel_four_config (
    // Clock and reset.
    input wire core_clk,
    input wire srst,
    // Avalon-MM slave.
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    // Source ticks.
    input wire pllTick,
    input wire primaryTick,
    input wire secondaryTick,
    // Channel 2/3 divided clock.
    output reg pairBClk,
    // Channel 4 pins.
    output wire out4Pos,
    output wire out4Neg,
    output wire out4PosOe,
    output wire out4NegOe,
    // Channel 4 driver settings.
    output wire out4LvdsSel,
    output wire out4LvcmosSel,
    output wire out4HcslSel,
    output reg out4EdgeRate,
    output reg out4SupplyLevel
);
`include "out4_cfg_map.vh"

    reg [15:0] ch23IntegerDivider_r;
    reg [15:0] ch4OutputConfig_r;
    reg [15:0] ch4DividerUpper_r;
    reg [15:0] ch4DividerLower_r;
    reg [31:0] readValue;
    reg out4Phase_r;
    reg prescaleCodeBad_r;
    reg [7:0] prescaleRatio;
    reg srcTick;
    reg [15:0] ch23IntegerDivider_nxt;
    reg [15:0] ch4OutputConfig_nxt;
    reg [15:0] ch4DividerUpper_nxt;
    reg [15:0] ch4DividerLower_nxt;
    reg [31:0] readData_nxt;
    reg waitRequest_nxt;

    wire [3:0] regIndex;
    wire addrAligned;
    wire writeNow;
    wire [15:0] laneMask;
    wire [15:0] maskedData;
    wire [7:0] pair_b_integer_ratio;
    wire [1:0] out4_source_select;
    wire [2:0] out4_prescale_code;
    wire out4_fractional_on;
    wire [7:0] out4_integer_ratio;
    wire [19:0] out4_fraction_value;
    wire prescaleTick;
    wire stageTick;
    wire out4Tick;
    wire pairBTick;
    wire [15:0] statusWord;

    // Bus decode: word index from the byte address, lanes 0 and 1 only.
    assign regIndex = avsAddress[5:2];
    assign addrAligned = (avsAddress[1:0] == 2'b00);
    assign writeNow = avsWrite && !avsWaitRequest && addrAligned;
    assign laneMask = {{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
    assign maskedData = avsWriteData[15:0] & laneMask;

    // Field extraction.
    assign pair_b_integer_ratio =
        ch23IntegerDivider_r[`PAIR_B_RATIO_HI:`PAIR_B_RATIO_LO];
    assign out4_source_select =
        ch4OutputConfig_r[`SRC_SEL_HI:`SRC_SEL_LO];
    assign out4_prescale_code =
        ch4OutputConfig_r[`PRESCALE_HI:`PRESCALE_LO];
    assign out4_fractional_on = ch4OutputConfig_r[`FRAC_ON_BIT];
    assign out4_integer_ratio =
        ch4DividerUpper_r[`OUT4_RATIO_HI:`OUT4_RATIO_LO];
    // The fraction spans two registers and each write lands on its own, so
    // software should change it while the fractional divider is off.
    assign out4_fraction_value = {
        ch4DividerUpper_r[`FRAC_TOP_HI:`FRAC_TOP_LO],
        ch4DividerLower_r};

    // Status is read-only and live, a debug view of the divided phases.
    assign statusWord = {12'h000, prescaleCodeBad_r, out4_fractional_on,
        out4Phase_r, pairBClk};

    // Register file. Only the non-reserved bits store; software is expected
    // to write zeros to the rest, and they read back as zero regardless.
    // Next values are worked out apart from the flops, so each register
    // has one plainly visible write condition.
    always @* begin
        ch23IntegerDivider_nxt = ch23IntegerDivider_r;
        ch4OutputConfig_nxt = ch4OutputConfig_r;
        ch4DividerUpper_nxt = ch4DividerUpper_r;
        ch4DividerLower_nxt = ch4DividerLower_r;
        if (writeNow) begin
            case (regIndex)
                `IDX_CH23_INTEGER_DIVIDER: begin
                    ch23IntegerDivider_nxt = (ch23IntegerDivider_r &
                        ~laneMask) | (maskedData &
                        `MASK_CH23_INTEGER_DIVIDER);
                end
                `IDX_CH4_OUTPUT_CONFIG: begin
                    ch4OutputConfig_nxt = (ch4OutputConfig_r &
                        ~laneMask) | (maskedData &
                        `MASK_CH4_OUTPUT_CONFIG);
                end
                `IDX_CH4_DIVIDER_UPPER: begin
                    ch4DividerUpper_nxt = (ch4DividerUpper_r &
                        ~laneMask) | (maskedData &
                        `MASK_CH4_DIVIDER_UPPER);
                end
                `IDX_CH4_DIVIDER_LOWER: begin
                    ch4DividerLower_nxt = (ch4DividerLower_r &
                        ~laneMask) | (maskedData &
                        `MASK_CH4_DIVIDER_LOWER);
                end
                default: begin
                    ch4DividerLower_nxt = ch4DividerLower_r;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            ch23IntegerDivider_r <= `RST_CH23_INTEGER_DIVIDER;
            ch4OutputConfig_r <= `RST_CH4_OUTPUT_CONFIG;
            ch4DividerUpper_r <= `RST_CH4_DIVIDER_UPPER;
            ch4DividerLower_r <= `RST_CH4_DIVIDER_LOWER;
        end else begin
            ch23IntegerDivider_r <= ch23IntegerDivider_nxt;
            ch4OutputConfig_r <= ch4OutputConfig_nxt;
            ch4DividerUpper_r <= ch4DividerUpper_nxt;
            ch4DividerLower_r <= ch4DividerLower_nxt;
        end
    end

    // Read mux; unmapped or unaligned addresses read as zero.
    always @* begin
        readValue = 32'h0000_0000;
        if (addrAligned) begin
            case (regIndex)
                `IDX_CH23_INTEGER_DIVIDER:
                    readValue = {16'h0000, ch23IntegerDivider_r};
                `IDX_CH4_OUTPUT_CONFIG:
                    readValue = {16'h0000, ch4OutputConfig_r};
                `IDX_CH4_DIVIDER_UPPER:
                    readValue = {16'h0000, ch4DividerUpper_r};
                `IDX_CH4_DIVIDER_LOWER:
                    readValue = {16'h0000, ch4DividerLower_r};
                `IDX_CH4_STATUS:
                    readValue = {16'h0000, statusWord};
                default:
                    readValue = 32'h0000_0000;
            endcase
        end
    end

    // Every access takes one wait cycle: waitrequest drops the cycle after
    // the request appears, and the write lands on the edge that sees it low.
    // This keeps read data registered at the cost of one cycle per access.
    always @* begin
        waitRequest_nxt = 1'b1;
        readData_nxt = avsReadData;
        if ((avsRead || avsWrite) && avsWaitRequest) begin
            waitRequest_nxt = 1'b0;
            readData_nxt = avsRead ? readValue : 32'h0000_0000;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h0000_0000;
        end else begin
            avsWaitRequest <= waitRequest_nxt;
            avsReadData <= readData_nxt;
        end
    end

    // Source mux and prescaler ratio.
    always @* begin
        case (out4_source_select)
            `SRC_PRIMARY: srcTick = primaryTick;
            `SRC_SECONDARY: srcTick = secondaryTick;
            default: srcTick = pllTick;
        endcase
        case (out4_prescale_code)
            `PRESCALE_DIV3: prescaleRatio = `RATIO_DIV3;
            `PRESCALE_DIV1: prescaleRatio = `RATIO_DIV1;
            default: prescaleRatio = `RATIO_DIV2;
        endcase
    end

    ratio_divider prescaler (
        .core_clk(core_clk),
        .srst(srst),
        .inTick(srcTick),
        .ratio(prescaleRatio),
        .fraction(20'h0_0000),
        .fracOn(1'b0),
        .outTick(prescaleTick)
    );

    // The prescaler only sits in the path of the fractional divider.
    assign stageTick = out4_fractional_on ? prescaleTick : srcTick;

    ratio_divider out4Divider (
        .core_clk(core_clk),
        .srst(srst),
        .inTick(stageTick),
        .ratio(out4_integer_ratio),
        .fraction(out4_fraction_value),
        .fracOn(out4_fractional_on),
        .outTick(out4Tick)
    );

    // Channels 2 and 3 always divide the PLL tick; they have no source mux.
    ratio_divider pairBDivider (
        .core_clk(core_clk),
        .srst(srst),
        .inTick(pllTick),
        .ratio(pair_b_integer_ratio),
        .fraction(20'h0_0000),
        .fracOn(1'b0),
        .outTick(pairBTick)
    );

    // Divided phases, settings pins and the reserved-code flag.
    always @(posedge core_clk) begin
        if (srst) begin
            pairBClk <= 1'b0;
            out4Phase_r <= 1'b0;
            prescaleCodeBad_r <= 1'b0;
            out4EdgeRate <= 1'b0;
            out4SupplyLevel <= 1'b0;
        end else begin
            if (pairBTick) begin
                pairBClk <= ~pairBClk;
            end
            if (out4Tick) begin
                out4Phase_r <= ~out4Phase_r;
            end
            prescaleCodeBad_r <= out4_fractional_on &&
                (out4_prescale_code != `PRESCALE_DIV2) &&
                (out4_prescale_code != `PRESCALE_DIV3) &&
                (out4_prescale_code != `PRESCALE_DIV1);
            out4EdgeRate <= ch4OutputConfig_r[`EDGE_RATE_BIT];
            // Follows the register at any time, so a wrong power-up value
            // can be corrected without a reset.
            out4SupplyLevel <= ch4OutputConfig_r[`SUPPLY_BIT];
        end
    end

    // Out of reset the negative pin is the complement of the positive one (reset drives both low), so a
    // differential driver sees both halves from one registered level.
    out_stage out4Stage (
        .core_clk(core_clk),
        .srst(srst),
        .phase(out4Phase_r),
        .control(ch4OutputConfig_r[`OUT_CTRL_HI:`OUT_CTRL_LO]),
        .driverType(ch4OutputConfig_r[`DRV_TYPE_HI:`DRV_TYPE_LO]),
        .posOn(ch4OutputConfig_r[`POS_ON_BIT]),
        .negOn(ch4OutputConfig_r[`NEG_ON_BIT]),
        .pinPos(out4Pos),
        .pinNeg(out4Neg),
        .pinPosOe(out4PosOe),
        .pinNegOe(out4NegOe),
        .lvdsSel(out4LvdsSel),
        .lvcmosSel(out4LvcmosSel),
        .hcslSel(out4HcslSel)
    );
endmodule // output_channel_four_config

/* tb/output_channel_four_config_assertions.sv */
/*
 Concurrent checks for the channel 4 output configuration block.
 Assumes one clock, core_clk, with synchronous active-high srst.
*/
module output_channel_four_config_checker (
    // Clock and reset.
    input wire core_clk,
    input wire srst,
    // Bus.
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    // Observed pins.
    input wire pllTick,
    input wire pairBClk,
    input wire out4PosOe,
    input wire out4NegOe,
    input wire out4LvdsSel,
    input wire out4LvcmosSel,
    input wire out4HcslSel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wire taken;
    assign taken = (avsRead || avsWrite) && avsWaitRequest;
    a_wait_answers: assert property (taken |=> !avsWaitRequest)
        else $error("Request not answered after one wait cycle.");
    a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("Wait request low for more than one cycle.");
    a_wait_cause: assert property ($fell(avsWaitRequest)
        |-> $past(taken))
        else $error("Wait request dropped without a request.");
    a_upper_zero: assert property (avsReadData[31:16] == 16'h0000)
        else $error("Upper read data lanes not zero.");
    a_unaligned_zero: assert property (taken && avsRead &&
        avsAddress[1:0] != 2'b00 |=> avsReadData == 32'h0000_0000)
        else $error("Unaligned read returned nonzero data.");
    a_write_clears: assert property (taken && avsWrite
        |=> avsReadData == 32'h0000_0000)
        else $error("Read data not cleared by a write.");
    a_driver_onehot: assert property ($onehot0({out4LvdsSel,
        out4LvcmosSel, out4HcslSel}))
        else $error("More than one driver type selected.");
    a_neg_needs_pos: assert property (out4NegOe && out4LvcmosSel
        |-> out4PosOe)
        else $error("Negative single-ended side on without positive.");
    a_oe_paired: assert property (!out4LvcmosSel
        |-> out4PosOe == out4NegOe)
        else $error("Differential enables differ.");
    a_pair_cause: assert property ($changed(pairBClk)
        |-> $past(pllTick) || $past(pllTick, 2))
        else $error("Pair clock moved without a source tick.");
    c_write: cover property (taken && avsWrite);
    c_unaligned: cover property (taken && avsRead && avsAddress[1:0] != 2'b00);
    c_pair_toggle: cover property ($changed(pairBClk));
endmodule // output_channel_four_config_checker

bind output_channel_four_config output_channel_four_config_checker chk (
    .core_clk(core_clk), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pllTick(pllTick),
    .pairBClk(pairBClk), .out4PosOe(out4PosOe), .out4NegOe(out4NegOe),
    .out4LvdsSel(out4LvdsSel), .out4LvcmosSel(out4LvcmosSel),
    .out4HcslSel(out4HcslSel));

/* tb/testbench.sv */
/*
 Self-checking bench for the channel 4 output configuration block.
 Assumes the register map header is on the include path.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`include "out4_cfg_map.vh"
    logic core_clk, srst, avsRead, avsWrite;
    logic pllTick, primaryTick, secondaryTick;
    logic [5:0] avsAddress;
    logic [31:0] avsWriteData, avsReadData;
    logic [3:0] avsByteEnable;
    logic avsWaitRequest, pairBClk, out4Pos, out4Neg, out4PosOe, out4NegOe;
    logic out4LvdsSel, out4LvcmosSel, out4HcslSel, out4EdgeRate;
    logic out4SupplyLevel, p4, pp;
    int n_mismatch, n_tests, t4, tp, src, s, r, pr, f, e;
    logic [15:0] d, cfg;
    logic [31:0] q;

    output_channel_four_config dut (.core_clk(core_clk), .srst(srst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .pllTick(pllTick), .primaryTick(primaryTick),
        .secondaryTick(secondaryTick), .pairBClk(pairBClk),
        .out4Pos(out4Pos), .out4Neg(out4Neg), .out4PosOe(out4PosOe),
        .out4NegOe(out4NegOe), .out4LvdsSel(out4LvdsSel),
        .out4LvcmosSel(out4LvcmosSel), .out4HcslSel(out4HcslSel),
        .out4EdgeRate(out4EdgeRate), .out4SupplyLevel(out4SupplyLevel));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Counted on the falling edge so the count never races the stimulus.
    always @(negedge core_clk) begin
        if (out4Pos !== p4) t4++;
        if (pairBClk !== pp) tp++;
        p4 = out4Pos;
        pp = pairBClk;
    end

    task stop_test;
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task bus(input logic wr, input logic [5:0] a, input logic [15:0] dat,
             input logic [3:0] be);
        int i;
        @(posedge core_clk);
        avsWrite <= wr;
        avsRead <= !wr;
        avsAddress <= a;
        avsWriteData <= {16'h0000, dat};
        avsByteEnable <= be;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (avsWaitRequest !== 1'b0 && i < 20);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (avsWaitRequest !== 1'b0) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    task rd(input logic [5:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000, 4'h3);
        chk("read data", {16'h0000, exp}, q);
    endtask

    function logic [15:0] mask(input logic [3:0] idx);
        case (idx)
            4'h8: return `MASK_CH23_INTEGER_DIVIDER;
            4'h9: return `MASK_CH4_OUTPUT_CONFIG;
            4'hA: return `MASK_CH4_DIVIDER_UPPER;
            4'hB: return `MASK_CH4_DIVIDER_LOWER;
            default: return 16'h0000;
        endcase
    endfunction

    // Order: lvds, lvcmos, hcsl, pos enable, neg enable, slew, supply, level.
    function logic [7:0] pin_exp(input logic [15:0] c);
        logic en, lv;
        en = c[2:1] != 2'b00;
        lv = c[4:3] == 2'b10;
        return {c[4:3] < 2'b10, lv, c[4:3] == 2'b11, en & (c[6] | !lv),
            en & ((c[6] & c[7]) | !lv), c[8], c[0], c[2:1] == 2'b11};
    endfunction

    task pins(input logic [15:0] c);
        logic [7:0] seen;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            seen = {out4LvdsSel, out4LvcmosSel, out4HcslSel, out4PosOe,
                out4NegOe, out4EdgeRate, out4SupplyLevel, out4Pos};
            if (seen === pin_exp(c)) break;
        end
        chk("pins", {24'h00_0000, pin_exp(c)}, {24'h00_0000, seen});
        chk("neg pin", !out4Pos, out4Neg);
    endtask

    // Pulses one source every other cycle and counts output toggles.
    task run(input int which, input int n);
        repeat (10) @(posedge core_clk);
        t4 = 0;
        tp = 0;
        repeat (n) begin
            @(posedge core_clk);
            pllTick <= which == 0;
            primaryTick <= which == 1;
            secondaryTick <= which == 2;
            @(posedge core_clk);
            {pllTick, primaryTick, secondaryTick} <= 3'b000;
        end
        repeat (10) @(posedge core_clk);
    endtask

    initial begin
        srst = 1'b1;
        {avsRead, avsWrite, pllTick, primaryTick, secondaryTick} = 5'h00;
        avsAddress = 6'h00;
        avsWriteData = 32'h0000_0000;
        avsByteEnable = 4'h0;
        n_mismatch = 0;
        n_tests = 0;
        void'($urandom(32'hb60e));
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 8; i < 12; i++) rd(6'(i << 2), 16'h0000);
        repeat (8) begin
            r = $urandom_range(11, 8);
            d = 16'($urandom()) & mask(4'(r));
            if (r == 9) d[7] = d[7] & d[6];
            bus(1'b1, 6'(r << 2), d, 4'h3);
            rd(6'(r << 2), d);
        end
        bus(1'b1, 6'h20, 16'hFF5A, 4'h3);
        rd(6'h20, 16'h005A);
        bus(1'b1, 6'h2C, 16'h1234, 4'h3);
        bus(1'b1, 6'h2C, 16'hABCD, 4'h1);
        rd(6'h2C, 16'h12CD);
        bus(1'b1, 6'h0C, 16'hFFFF, 4'h3);
        rd(6'h0C, 16'h0000);
        rd(6'h25, 16'h0000);
        for (int t = 0; t < 12; t++) begin
            cfg = 16'($urandom()) & 16'h01C1;
            cfg[7] = cfg[7] & cfg[6];
            cfg[4:3] = 2'(t % 4);
            cfg[2:1] = (t / 4 == 0) ? 2'b00 : 2'(1 + t / 4);
            bus(1'b1, 6'h24, cfg, 4'h3);
            pins(cfg);
        end
        bus(1'b1, 6'h2C, 16'h0000, 4'h3);
        for (src = 0; src < 4; src++) for (s = 0; s < 3; s++) begin
            r = $urandom_range(3, 0);
            pr = $urandom_range(3, 0);
            cfg = 16'((src << 13) | ($urandom_range(7, 0) << 10)) | 16'h0002;
            bus(1'b1, 6'h24, cfg, 4'h3);
            bus(1'b1, 6'h28, 16'(r << 4), 4'h3);
            bus(1'b1, 6'h20, 16'(pr), 4'h3);
            run(s, 4 * (r + 1));
            e = (s == (src % 3 == 0 ? 0 : src)) ? 4 : 0;
            chk("out4 toggles", 1, t4 >= e - 1 && t4 <= e + 1);
            e = (s == 0) ? 4 * (r + 1) / (pr + 1) : 0;
            chk("pair toggles", 1, tp >= e - 1 && tp <= e + 1);
        end
        for (int c = 0; c < 3; c++) begin
            f = (c == 0) ? 2 : (c == 1) ? 3 : 1;
            r = $urandom_range(3, 0);
            cfg = (c == 2 ? 16'h1C00 : 16'(c << 10)) | 16'h2202;
            bus(1'b1, 6'h24, cfg, 4'h3);
            bus(1'b1, 6'h28, 16'(r << 4), 4'h3);
            run(1, 4 * (r + 1) * f);
            chk("prescaled toggles", 1, t4 >= 3 && t4 <= 5);
        end
        stop_test();
    end
endmodule // testbench
